// file: core/bcc_defines.svh
// constants of the bus clock and external bus control block
// Behaviour
// - bus clock is oscillator divided by four; with bypass set it follows the oscillator level directly
// - every clock derives from oscillator input, except the bus clock in special peripheral mode, taken from the pin
// - normal single-chip: clock pin off after reset
// - special single-chip: clock pin on from reset
// - special peripheral: clock pin is input
// - stop mode halts all clocks except the bus clock taken from the pin in special peripheral mode
// - bus clock high phase stretchable for slow memory
// - bus clock separates address and data phases
// - narrow mode alternates high, low bytes
`ifndef BCC_DEFINES_SVH
`define BCC_DEFINES_SVH

`define BCC_ADDR_W      4
`define BCC_OFF_CTRL    4'h0
`define BCC_OFF_STAT    4'h4
`define BCC_OFF_ADDR    4'h8
`define BCC_OFF_DATA    4'hc

`define BCC_CTRL_EN     0
`define BCC_CTRL_BYP    1
`define BCC_CTRL_NAR    2
`define BCC_CTRL_STR_LO 4
`define BCC_CTRL_STR_HI 5

`define BCC_STRAP_NSC   2'h0
`define BCC_STRAP_EXP   2'h1
`define BCC_STRAP_SSC   2'h2
`define BCC_STRAP_SPER  2'h3

`define BCC_CNT_W       3
`define BCC_HALF_CNT    3'h1
`define BCC_STRAP_DLY   2'h2
`define BCC_CTRL_RST    5'h00

`endif

// file: core/bcc_pkg.sv
// types shared by the bus clock control block
`include "bcc_defines.svh"
package bcc_pkg;

    typedef logic [1:0] bcc_strap_t;

    typedef enum logic [1:0] {
        BCC_MODE_NSC,
        BCC_MODE_EXP,
        BCC_MODE_SSC,
        BCC_MODE_SPER
    } bcc_mode_e;

    typedef enum logic {
        BCC_PH_LOW,
        BCC_PH_HIGH
    } bcc_phase_e;

    typedef struct packed {
        logic [1:0] stretch;
        logic       narrow;
        logic       bypass;
        logic       en;
    } bcc_ctrl_s;

    typedef struct packed {
        logic       stop;
        logic       bypass;
        logic [1:0] stretch;
    } bcc_div_cfg_s;

endpackage : bcc_pkg

// file: core/bcc_clk_divider.sv
// oscillator-edge divider that builds the internal bus clock phase
`timescale 1ns/1ps
`include "bcc_defines.svh"
module bcc_clk_divider (
    input  wire logic                core_clk,
    input  wire logic                nrst,
    input  wire logic                oscRise,
    input  wire logic                oscLevel,
    input  wire bcc_pkg::bcc_div_cfg_s cfg,
    output logic                     busPhase,
    output logic                     cycleEnd
);
    import bcc_pkg::*;

    bcc_phase_e             ph;
    logic [`BCC_CNT_W-1:0]  cnt;
    logic [`BCC_CNT_W-1:0]  limit;
    logic                   highDone;

    assign limit    = `BCC_HALF_CNT + {cfg.stretch, 1'b0};
    assign highDone = oscRise && ph == BCC_PH_HIGH && cnt >= limit;
    assign busPhase = (ph == BCC_PH_HIGH);

    ////////////////////////////////////////////////////////////////////////
    // two oscillator rises per low phase, two or more per high phase
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ph  <= BCC_PH_LOW;
            cnt <= '0;
        end else if (cfg.stop) begin
            ph  <= BCC_PH_LOW;
            cnt <= '0;
        end else if (cfg.bypass) begin
            ph  <= oscLevel ? BCC_PH_HIGH : BCC_PH_LOW;
            cnt <= '0;
        end else if (oscRise) begin
            case (ph)
                BCC_PH_LOW: begin
                    if (cnt >= `BCC_HALF_CNT) begin
                        ph  <= BCC_PH_HIGH;
                        cnt <= '0;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                BCC_PH_HIGH: begin
                    if (cnt >= limit) begin
                        ph  <= BCC_PH_LOW;
                        cnt <= '0;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                default: begin
                    ph  <= BCC_PH_LOW;
                    cnt <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cycleEnd <= 1'b0;
        end else if (cfg.stop) begin
            cycleEnd <= 1'b0;
        end else if (cfg.bypass) begin
            cycleEnd <= (ph == BCC_PH_HIGH) && !oscLevel;
        end else begin
            cycleEnd <= highDone;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_div_low_hold;
        @(posedge core_clk) disable iff (!nrst)
        (oscRise && ph == BCC_PH_LOW && cnt == '0 && !cfg.stop
            && !cfg.bypass) |=> ph == BCC_PH_LOW;
    endproperty
    a_div_low_hold: assert property (p_div_low_hold)
        else $error("low phase ended after one oscillator rise");

    property p_div_rise;
        @(posedge core_clk) disable iff (!nrst)
        (oscRise && ph == BCC_PH_LOW && cnt == `BCC_HALF_CNT
            && !cfg.stop && !cfg.bypass) |=> ph == BCC_PH_HIGH;
    endproperty
    a_div_rise: assert property (p_div_rise)
        else $error("high phase missing after two oscillator rises");

    property p_div_stretch;
        @(posedge core_clk) disable iff (!nrst)
        (oscRise && ph == BCC_PH_HIGH && cnt == `BCC_HALF_CNT
            && cfg.stretch != 2'h0 && !cfg.stop && !cfg.bypass)
            |=> ph == BCC_PH_HIGH;
    endproperty
    a_div_stretch: assert property (p_div_stretch)
        else $error("stretched high phase ended early");

    property p_div_stop;
        @(posedge core_clk) disable iff (!nrst)
        cfg.stop [*2] |-> !busPhase && !cycleEnd;
    endproperty
    a_div_stop: assert property (p_div_stop)
        else $error("bus clock phase moved during stop");

endmodule : bcc_clk_divider

// file: core/bcc_bus_clock_output.sv
// bus clock generation, clock pin control and external bus muxing
`timescale 1ns/1ps
`include "bcc_defines.svh"
module bcc_bus_clock_output (
    input  wire logic                       core_clk,
    input  wire logic                       nrst,
    input  wire logic                       oscIn,
    output logic                            oscDriveOut,
    input  wire logic                       busClockIn,
    output logic                            busClockOut,
    output logic                            busClockOe,
    input  wire bcc_pkg::bcc_strap_t        modeStrap,
    input  wire logic                       stopReq,
    output logic [7:0]                      portA,
    output logic [7:0]                      portB,
    output logic                            portOe,
    input  wire logic [`BCC_ADDR_W-1:0]     address,
    input  wire logic                       read,
    input  wire logic                       write,
    input  wire logic [31:0]                writedata,
    output logic [31:0]                     readdata,
    output logic                            waitrequest
);
    import bcc_pkg::*;

    logic [3:0]             pinMeta;
    logic [3:0]             pinSync;
    logic                   oscPrev;
    logic                   extPrev;
    logic [1:0]             strapCnt;
    logic                   strapped;
    bcc_mode_e              modeSel;
    bcc_ctrl_s              ctrl;
    logic [15:0]            xferAddr;
    logic [15:0]            xferData;
    logic                   xferBusy;
    logic                   xferPend;
    logic                   byteSel;
    logic                   isPer;
    logic                   divPhase;
    logic                   divEnd;
    logic                   phase;
    logic                   cycleEnd;
    logic                   wrAcc;
    logic                   clkDrive;
    bcc_div_cfg_s           divCfg;

    function automatic bcc_mode_e decodeMode(input bcc_strap_t s);
        case (s)
            `BCC_STRAP_EXP:  decodeMode = BCC_MODE_EXP;
            `BCC_STRAP_SSC:  decodeMode = BCC_MODE_SSC;
            `BCC_STRAP_SPER: decodeMode = BCC_MODE_SPER;
            default:         decodeMode = BCC_MODE_NSC;
        endcase
    endfunction : decodeMode

    function automatic logic [31:0] regRead(
        input logic [`BCC_ADDR_W-1:0] a);
        case (a)
            `BCC_OFF_CTRL: regRead = {26'h0, ctrl.stretch, 1'b0,
                                      ctrl.narrow, ctrl.bypass, ctrl.en};
            `BCC_OFF_STAT: regRead = {26'h0, byteSel, stopReq,
                                      xferBusy || xferPend, phase, modeSel};
            `BCC_OFF_ADDR: regRead = {16'h0, xferAddr};
            `BCC_OFF_DATA: regRead = {16'h0, xferData};
            default:       regRead = 32'h0;
        endcase
    endfunction : regRead

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: straps, external bus clock and oscillator
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pinMeta <= 4'h0;
            pinSync <= 4'h0;
        end else begin
            pinMeta <= {modeStrap, busClockIn, oscIn};
            pinSync <= pinMeta;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            oscPrev <= 1'b0;
            extPrev <= 1'b0;
        end else begin
            oscPrev <= pinSync[0];
            extPrev <= pinSync[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // straps are taken once the synchroniser holds post-reset levels
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            strapCnt <= 2'h0;
            strapped <= 1'b0;
            modeSel  <= BCC_MODE_NSC;
        end else if (!strapped) begin
            if (strapCnt == `BCC_STRAP_DLY) begin
                strapped <= 1'b1;
                modeSel  <= decodeMode(pinSync[3:2]);
            end else begin
                strapCnt <= strapCnt + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait cycle, then read data and write commit
    assign wrAcc = write && !waitrequest;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            waitrequest <= 1'b1;
            readdata    <= 32'h0;
        end else begin
            waitrequest <= !((read || write) && waitrequest);
            if (read && waitrequest) begin
                readdata <= regRead(address);
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl <= `BCC_CTRL_RST;
        end else if (wrAcc && address == `BCC_OFF_CTRL) begin
            ctrl.en      <= writedata[`BCC_CTRL_EN];
            ctrl.bypass  <= writedata[`BCC_CTRL_BYP];
            ctrl.narrow  <= writedata[`BCC_CTRL_NAR];
            ctrl.stretch <= writedata[`BCC_CTRL_STR_HI:`BCC_CTRL_STR_LO];
        end else if (!strapped && strapCnt == `BCC_STRAP_DLY) begin
            // pin starts on only in special single-chip mode
            ctrl.en <= (decodeMode(pinSync[3:2]) == BCC_MODE_SSC);
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            xferAddr <= 16'h0;
            xferData <= 16'h0;
        end else if (wrAcc && address == `BCC_OFF_ADDR) begin
            xferAddr <= writedata[15:0];
        end else if (wrAcc && address == `BCC_OFF_DATA) begin
            xferData <= writedata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus clock source: own divider, or the pin in peripheral mode
    assign isPer          = (modeSel == BCC_MODE_SPER);
    assign divCfg.stop    = stopReq;
    assign divCfg.bypass  = ctrl.bypass;
    // stretching only applies while an external transfer is running
    assign divCfg.stretch = xferBusy ? ctrl.stretch : 2'h0;

    bcc_clk_divider u_div (
        .core_clk (core_clk),
        .nrst     (nrst),
        .oscRise  (pinSync[0] && !oscPrev),
        .oscLevel (pinSync[0]),
        .cfg      (divCfg),
        .busPhase (divPhase),
        .cycleEnd (divEnd)
    );

    assign phase    = isPer ? extPrev : divPhase;
    assign cycleEnd = isPer ? (extPrev && !pinSync[1]) : divEnd;
    assign clkDrive = ctrl.en && !isPer;

    ////////////////////////////////////////////////////////////////////////
    // transfer sequencing; a start waits for a bus cycle boundary so the
    // address phase always comes first; a new start wins over a finish
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            xferPend <= 1'b0;
            xferBusy <= 1'b0;
            byteSel  <= 1'b0;
        end else if (wrAcc && address == `BCC_OFF_DATA) begin
            xferPend <= 1'b1;
            xferBusy <= 1'b0;
            byteSel  <= 1'b0;
        end else if (cycleEnd) begin
            if (xferPend) begin
                xferPend <= 1'b0;
                xferBusy <= 1'b1;
            end else if (xferBusy && ctrl.narrow && !byteSel) begin
                byteSel <= 1'b1;
            end else begin
                xferBusy <= 1'b0;
                byteSel  <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drivers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            busClockOut <= 1'b0;
            busClockOe  <= 1'b0;
        end else begin
            busClockOe  <= clkDrive;
            // disabled pin parks low instead of toggling
            busClockOut <= clkDrive && phase;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            oscDriveOut <= 1'b0;
        end else begin
            // oscillator drive stops too, so nothing can restart early
            oscDriveOut <= !stopReq && !pinSync[0];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            portA  <= 8'h00;
            portB  <= 8'h00;
            portOe <= 1'b0;
        end else begin
            portOe <= xferBusy && !isPer;
            if (!phase) begin
                portA <= xferAddr[15:8];
                portB <= xferAddr[7:0];
            end else if (ctrl.narrow) begin
                portA <= byteSel ? xferData[7:0] : xferData[15:8];
                portB <= xferAddr[7:0];
            end else begin
                portA <= xferData[15:8];
                portB <= xferData[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_nsc_off;
        @(posedge core_clk) disable iff (!nrst)
        ($rose(strapped) && modeSel == BCC_MODE_NSC) |=> !busClockOe;
    endproperty
    a_nsc_off: assert property (p_nsc_off)
        else $error("clock pin driven in normal single-chip mode");

    property p_ssc_on;
        @(posedge core_clk) disable iff (!nrst)
        ($rose(strapped) && modeSel == BCC_MODE_SSC) |=> busClockOe;
    endproperty
    a_ssc_on: assert property (p_ssc_on)
        else $error("clock pin off in special single-chip mode");

    property p_per_in;
        @(posedge core_clk) disable iff (!nrst)
        (strapped && isPer) |=> !busClockOe;
    endproperty
    a_per_in: assert property (p_per_in)
        else $error("clock pin driven in peripheral mode");

    property p_off_static;
        @(posedge core_clk) disable iff (!nrst)
        !clkDrive |=> !busClockOut;
    endproperty
    a_off_static: assert property (p_off_static)
        else $error("disabled clock pin not held low");

    property p_narrow_seq;
        @(posedge core_clk) disable iff (!nrst)
        (xferBusy && cycleEnd && ctrl.narrow && !byteSel
            && !(wrAcc && address == `BCC_OFF_DATA))
            |=> xferBusy && byteSel;
    endproperty
    a_narrow_seq: assert property (p_narrow_seq)
        else $error("narrow transfer skipped its low byte");

    property p_addr_phase;
        @(posedge core_clk) disable iff (!nrst)
        (!phase && xferBusy) |=> portA == $past(xferAddr[15:8]);
    endproperty
    a_addr_phase: assert property (p_addr_phase)
        else $error("address missing in low bus clock phase");

endmodule : bcc_bus_clock_output

// file: verification/bcc_ext_bus_model.sv
// expansion bus partner: times the bus clock phases and samples the ports
`timescale 1ns/1ps
module bcc_ext_bus_model (
    input  wire logic        core_clk,
    input  wire logic        oscIn,
    input  wire logic        busClockOut,
    input  wire logic        portOe,
    input  wire logic [7:0]  portA,
    input  wire logic [7:0]  portB,
    input  wire logic        extEn,
    input  wire logic        extLevel,
    output logic             extClk,
    output logic [15:0]      addrCap,
    output logic [15:0]      wideCap,
    output logic [15:0]      byteHist,
    output logic [7:0]       loLen,
    output logic [7:0]       hiLen,
    output logic [7:0]       xferHi
);
    logic        oscPrev = 1'b0;
    logic        clkPrev = 1'b0;
    logic        hiXfer  = 1'b0;
    logic [7:0]  phCnt   = 8'h00;
    logic [7:0]  curA;
    logic [15:0] curW;
    initial extClk = 1'b0;
    //////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk) begin
        oscPrev <= oscIn;
        clkPrev <= busClockOut;
        hiXfer  <= portOe & busClockOut;
        // released pin keeps changing so a stale level is never read as valid
        extClk  <= extEn ? extLevel : ~extClk;
        if (busClockOut !== clkPrev) begin
            phCnt <= 8'h00;
            if (busClockOut) begin
                loLen <= phCnt;
            end else begin
                hiLen <= phCnt;
                if (hiXfer) begin
                    xferHi   <= phCnt;
                    byteHist <= {byteHist[7:0], curA};
                    wideCap  <= curW;
                end
            end
        end else if (oscIn && !oscPrev) begin
            phCnt <= phCnt + 8'h01;
        end
        // low phase carries the address, high phase the data
        if (portOe && !busClockOut) addrCap <= {portA, portB};
        if (portOe && busClockOut) begin
            curA <= portA;
            curW <= {portA, portB};
        end
    end
endmodule : bcc_ext_bus_model

// file: verification/tb_bus_clock_output_control.sv
// testbench of the bus clock output block
`timescale 1ns/1ps
`include "bcc_defines.svh"
module tb_bus_clock_output_control;
    logic               core_clk = 1'b0;
    logic               nrst = 1'b0;
    logic               oscIn = 1'b0;
    logic [2:0]         oscCnt = 3'h0;
    logic               busClockIn;
    bcc_pkg::bcc_strap_t modeStrap = `BCC_STRAP_NSC;
    logic               stopReq = 1'b0;
    logic [3:0]         address = 4'h0;
    logic               read = 1'b0;
    logic               write = 1'b0;
    logic [31:0]        writedata = 32'h0;
    logic               extEn = 1'b0;
    logic               extLevel = 1'b0;
    logic               oscDriveOut, busClockOut, busClockOe, portOe;
    logic               extClk, waitrequest;
    logic [7:0]         portA, portB, loLen, hiLen, xferHi;
    logic [15:0]        addrCap, wideCap, byteHist;
    logic [31:0]        readdata, q;
    int                 err_count = 0;
    int                 comparisons = 0;
    assign busClockIn = busClockOe ? busClockOut : extClk;
    initial forever #4 core_clk = ~core_clk;
    // oscillator at one sixteenth of the core clock
    always @(posedge core_clk) begin
        oscCnt <= oscCnt + 3'h1;
        if (oscCnt == 3'h7) oscIn <= ~oscIn;
    end
    //////////////////////////////////////////////////////////////////////////
    bcc_bus_clock_output u_dut (.core_clk(core_clk), .nrst(nrst),
        .oscIn(oscIn), .oscDriveOut(oscDriveOut), .busClockIn(busClockIn),
        .busClockOut(busClockOut), .busClockOe(busClockOe),
        .modeStrap(modeStrap), .stopReq(stopReq), .portA(portA),
        .portB(portB), .portOe(portOe), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest));
    bcc_ext_bus_model u_mem (.core_clk(core_clk), .oscIn(oscIn),
        .busClockOut(busClockOut), .portOe(portOe), .portA(portA),
        .portB(portB), .extEn(extEn), .extLevel(extLevel), .extClk(extClk),
        .addrCap(addrCap), .wideCap(wideCap), .byteHist(byteHist),
        .loLen(loLen), .hiLen(hiLen), .xferHi(xferHi));
    //////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus_io(input logic wr, input logic [3:0] a,
                          input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge core_clk);
        address   <= a;
        writedata <= d;
        read      <= !wr;
        write     <= wr;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        if (waitrequest !== 1'b0) begin
            err_count++;
            tally_and_finish();
        end
        r = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask : bus_io
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus_io(1'b1, a, d, r);
    endtask : wr
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            bus_io(1'b0, `BCC_OFF_STAT, 32'h0, q);
            n++;
        end while (q[3] !== 1'b0 && n < 300);
        if (q[3] !== 1'b0) begin
            err_count++;
            tally_and_finish();
        end
    endtask : wait_idle
    task automatic do_reset(input logic [1:0] st);
        nrst      <= 1'b0;
        modeStrap <= st;
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (6) @(posedge core_clk);
    endtask : do_reset
    // pin must stay quiet; with stopChk the oscillator drive is watched instead of the pin enable
    task automatic hold_low(input int n, input logic stopChk);
        logic bad;
        bad = 1'b0;
        repeat (n) begin
            @(posedge core_clk);
            bad |= (busClockOut !== 1'b0);
            bad |= stopChk ? (oscDriveOut !== 1'b0) : (busClockOe !== 1'b0);
        end
        chk({31'h0, bad}, 32'h0);
    endtask : hold_low
    //////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge core_clk);
        err_count++;
        tally_and_finish();
    end
    initial begin
        do_reset(`BCC_STRAP_NSC);
        hold_low(200, 1'b0);
        bus_io(1'b0, `BCC_OFF_CTRL, 32'h0, q);
        chk(q, 32'h0);
        wr(4'h2, 32'hffffffff);
        bus_io(1'b0, 4'h2, 32'h0, q);
        chk(q, 32'h0);
        wr(`BCC_OFF_STAT, 32'hffffffff);
        bus_io(1'b0, `BCC_OFF_STAT, 32'h0, q);
        chk(q & 32'h3, 32'h0);
        repeat (4) begin
            for (int i = 0; i < 16 && oscCnt != 3'h6; i++) @(posedge core_clk);
            chk({31'h0, oscDriveOut}, {31'h0, ~oscIn});
            @(posedge core_clk);
        end
        wr(`BCC_OFF_CTRL, 32'h1);
        repeat (200) @(posedge core_clk);
        chk({31'h0, busClockOe}, 32'h1);
        chk({24'h0, loLen}, 32'h2);
        chk({24'h0, hiLen}, 32'h2);
        stopReq <= 1'b1;
        repeat (4) @(posedge core_clk);
        hold_low(200, 1'b1);
        stopReq <= 1'b0;
        for (int i = 0; i < 100 && busClockOut !== 1'b1; i++)
            @(posedge core_clk);
        chk({31'h0, busClockOut}, 32'h1);
        repeat (200) @(posedge core_clk);
        chk({24'h0, hiLen}, 32'h2);
        wr(`BCC_OFF_CTRL, 32'h3);
        repeat (100) @(posedge core_clk);
        chk({24'h0, loLen}, 32'h1);
        chk({24'h0, hiLen}, 32'h0);
        for (int s = 0; s < 4; s++) begin
            wr(`BCC_OFF_CTRL, 32'h1 | (s << 4));
            wr(`BCC_OFF_ADDR, 32'h1234 + s);
            wr(`BCC_OFF_DATA, 32'hc35a ^ s);
            wait_idle();
            chk({16'h0, addrCap}, 32'h1234 + s);
            chk({16'h0, wideCap}, 32'hc35a ^ s);
            chk({24'h0, xferHi}, 2 + 2 * s);
        end
        wr(`BCC_OFF_CTRL, 32'h5);
        wr(`BCC_OFF_ADDR, 32'h0f1e);
        wr(`BCC_OFF_DATA, 32'ha55a);
        wait_idle();
        chk({16'h0, byteHist}, 32'ha55a);
        chk({16'h0, addrCap}, 32'h0f1e);
        do_reset(`BCC_STRAP_SSC);
        chk({31'h0, busClockOe}, 32'h1);
        bus_io(1'b0, `BCC_OFF_CTRL, 32'h0, q);
        chk(q & 32'h1, 32'h1);
        wr(`BCC_OFF_CTRL, 32'h0);
        repeat (4) @(posedge core_clk);
        hold_low(100, 1'b0);
        extEn    <= 1'b1;
        extLevel <= 1'b1;
        do_reset(`BCC_STRAP_SPER);
        wr(`BCC_OFF_CTRL, 32'h1);
        hold_low(100, 1'b0);
        bus_io(1'b0, `BCC_OFF_STAT, 32'h0, q);
        chk(q & 32'h7, 32'h7);
        extLevel <= 1'b0;
        repeat (8) @(posedge core_clk);
        bus_io(1'b0, `BCC_OFF_STAT, 32'h0, q);
        chk(q & 32'h7, 32'h3);
        do_reset(`BCC_STRAP_EXP);
        bus_io(1'b0, `BCC_OFF_STAT, 32'h0, q);
        chk(q & 32'h3, 32'h1);
        wr(`BCC_OFF_CTRL, 32'h1);
        wr(`BCC_OFF_ADDR, 32'h5a0f);
        wr(`BCC_OFF_DATA, 32'h3cc3);
        wait_idle();
        chk({16'h0, addrCap}, 32'h5a0f);
        chk({16'h0, wideCap}, 32'h3cc3);
        tally_and_finish();
    end
endmodule : tb_bus_clock_output_control
